// ### verilog/serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// register indices (word addresses on the plain register port)
`define REG_CMD_SRC        4'h0
`define REG_LINK_SPEED     4'h1
`define REG_NODE_ADDR      4'h2
`define REG_CHAR_LEN       4'h3
`define REG_PARITY         4'h4
`define REG_STOP_BITS      4'h5
`define REG_REPLY_WAIT     4'h6
`define REG_STATUS         4'h7
`define REG_TX_DATA        4'h8
`define REG_RX_DATA        4'h9

// reset values
`define CMD_SRC_RESET      8'h02
`define LINK_SPEED_RESET   8'h04
`define NODE_ADDR_RESET    8'h01
`define CHAR_LEN_RESET     8'h07
`define PARITY_RESET       8'h00
`define STOP_BITS_RESET    8'h01
`define REPLY_WAIT_RESET   16'h0000

// legal ranges
`define NODE_ADDR_MIN      8'h01
`define NODE_ADDR_MAX      8'h20
`define REPLY_WAIT_MAX_MS  16'h03E8

// status bit positions
`define ST_RX_VALID        0
`define ST_RX_ERROR        1
`define ST_TX_BUSY         2
`define ST_ADDR_MATCH      3
`define ST_REPLY_PEND      4

// timing
`define CLK_HZ             125000000
`define TICK_MS_CYCLES     (`CLK_HZ / 1000)
`define BAUD_TEST_DIV      16'h0010

`endif

// ### verilog/serial_port_pkg.sv
package serial_port_pkg;

    typedef enum logic [7:0] {
        SRC_OPERATOR = 8'h02,
        SRC_SERIAL   = 8'h03,
        SRC_SLOT1    = 8'h04,
        SRC_SLOT2    = 8'h05
    } cmd_source_type;

    typedef enum logic [7:0] {
        PAR_NONE = 8'h00,
        PAR_EVEN = 8'h01,
        PAR_ODD  = 8'h02
    } parity_type;

    typedef struct packed {
        logic [15:0] bit_div;
        logic        eight_bits;
        logic [1:0]  parity;
        logic        two_stops;
    } frame_cfg_type;

    typedef struct packed {
        logic       valid;
        logic       error;
        logic [7:0] data;
    } rx_char_type;

endpackage

// ### verilog/serial_rx.sv
`timescale 1ns/100ps
`include "serial_port_defs.svh"

module serial_rx
    import serial_port_pkg::*;
(
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // configuration
    input  wire frame_cfg_type cfg_i,
    // line (already synchronised)
    input  wire logic          rx_i,
    // received character, one-cycle valid
    output rx_char_type        char_o
);

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_type;

    rx_state_type state_q;
    logic [15:0]  cnt_q;
    logic [3:0]   bit_q;
    logic [7:0]   shift_q;
    logic         par_q;
    logic         perr_q;
    rx_char_type  char_q;

    wire          has_par   = (cfg_i.parity != 2'h0);
    wire  [3:0]   nbits     = (cfg_i.eight_bits ? 4'h8 : 4'h7) + {3'h0, has_par};
    wire          cnt_done  = (cnt_q == 16'h0000);
    wire  [15:0]  half_div  = {1'b0, cfg_i.bit_div[15:1]};
    // odd parity expects the xor of data and parity bit to be one
    wire          par_bad   = has_par && ((par_q ^ (cfg_i.parity == 2'h2)) != 1'b0);

    assign char_o = char_q;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= RX_IDLE;
            cnt_q   <= 16'h0000;
            bit_q   <= 4'h0;
            shift_q <= 8'h00;
            par_q   <= 1'b0;
            perr_q  <= 1'b0;
            char_q  <= '0;
        end
        else
        begin
            char_q.valid <= 1'b0;
            if (!cnt_done)
                cnt_q <= cnt_q - 16'h0001;
            case (state_q)
                RX_IDLE:
                    if (!rx_i)
                    begin
                        state_q <= RX_START;
                        cnt_q   <= half_div;
                    end
                RX_START:
                    if (cnt_done)
                    begin
                        // glitch shorter than half a bit is dropped
                        state_q <= rx_i ? RX_IDLE : RX_DATA;
                        cnt_q   <= cfg_i.bit_div - 16'h0001;
                        bit_q   <= 4'h0;
                        par_q   <= 1'b0;
                        shift_q <= 8'h00;
                    end
                RX_DATA:
                    if (cnt_done)
                    begin
                        // counter runs down to zero inclusive, so reload one short
                        cnt_q <= cfg_i.bit_div - 16'h0001;
                        par_q <= par_q ^ rx_i;
                        if (bit_q < (cfg_i.eight_bits ? 4'h8 : 4'h7))
                            shift_q <= cfg_i.eight_bits ? {rx_i, shift_q[7:1]}
                                                        : {1'b0, rx_i, shift_q[6:1]};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q + 4'h1 == nbits)
                            state_q <= RX_STOP;
                    end
                RX_STOP:
                    if (cnt_done)
                    begin
                        // only the first stop bit is checked
                        char_q.valid <= 1'b1;
                        char_q.error <= !rx_i || par_bad;
                        char_q.data  <= shift_q;
                        state_q      <= RX_IDLE;
                    end
                default:
                    state_q <= RX_IDLE;
            endcase
        end
    end

endmodule

// ### verilog/serial_slave_port.sv
`timescale 1ns/100ps
`include "serial_port_defs.svh"

module serial_slave_port
    import serial_port_pkg::*;
#(
    parameter int unsigned TICK_MS = `TICK_MS_CYCLES
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // rs485 line
    input  wire logic        line_rx_i,
    output logic             line_tx_o,
    output logic             line_tx_oe_o,
    // configuration seen by the drive
    output logic      [7:0]  cmd_source_o,
    output logic             serial_cmd_en_o
);

    // configuration registers
    logic [7:0]  command_source_select_q;
    logic [7:0]  link_speed_select_q;
    logic [7:0]  node_address_setting_q;
    logic [7:0]  char_length_select_q;
    logic [7:0]  parity_select_q;
    logic [7:0]  stop_bits_select_q;
    logic [15:0] reply_wait_time_q;
    logic [15:0] rdata_q;

    // line sync
    logic        rx_meta_q;
    logic        rx_sync_q;

    // reply path
    logic        addr_match_q;
    logic        first_char_q;
    logic        rx_valid_q;
    logic        rx_error_q;
    logic [7:0]  rx_data_q;
    logic        pend_q;
    logic [7:0]  tx_hold_q;
    logic [15:0] ms_cnt_q;
    logic [31:0] tick_q;
    logic        tx_q;
    logic        oe_q;
    logic [15:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [11:0] tx_shift_q;
    logic        tx_busy_q;

    rx_char_type   rx_char;
    frame_cfg_type cfg;

    // speed divider for each code; test speed is a fast fixed rate
    function automatic logic [15:0] speed_div(input logic [7:0] code);
        case (code)
            8'h02:   speed_div = `BAUD_TEST_DIV;
            8'h03:   speed_div = 16'(`CLK_HZ / 2400);
            8'h04:   speed_div = 16'(`CLK_HZ / 4800);
            8'h05:   speed_div = 16'(`CLK_HZ / 9600);
            8'h06:   speed_div = 16'(`CLK_HZ / 19200);
            default: speed_div = 16'(`CLK_HZ / 4800);
        endcase
    endfunction

    assign cfg.bit_div    = speed_div(link_speed_select_q);
    assign cfg.eight_bits = (char_length_select_q == 8'h08);
    assign cfg.parity     = parity_select_q[1:0];
    assign cfg.two_stops  = (stop_bits_select_q == 8'h02);

    // write qualification: out of range codes are ignored
    wire wr_src   = reg_wr_i && reg_addr_i == `REG_CMD_SRC
                    && reg_wdata_i >= 16'h0002 && reg_wdata_i <= 16'h0005;
    wire wr_speed = reg_wr_i && reg_addr_i == `REG_LINK_SPEED
                    && reg_wdata_i >= 16'h0002 && reg_wdata_i <= 16'h0006;
    wire wr_node  = reg_wr_i && reg_addr_i == `REG_NODE_ADDR
                    && reg_wdata_i >= {8'h00, `NODE_ADDR_MIN}
                    && reg_wdata_i <= {8'h00, `NODE_ADDR_MAX};
    wire wr_len   = reg_wr_i && reg_addr_i == `REG_CHAR_LEN
                    && (reg_wdata_i == 16'h0007 || reg_wdata_i == 16'h0008);
    wire wr_par   = reg_wr_i && reg_addr_i == `REG_PARITY
                    && reg_wdata_i <= 16'h0002;
    wire wr_stop  = reg_wr_i && reg_addr_i == `REG_STOP_BITS
                    && (reg_wdata_i == 16'h0001 || reg_wdata_i == 16'h0002);
    wire wr_wait  = reg_wr_i && reg_addr_i == `REG_REPLY_WAIT
                    && reg_wdata_i <= `REPLY_WAIT_MAX_MS;
    wire wr_tx    = reg_wr_i && reg_addr_i == `REG_TX_DATA;
    wire rd_rx    = reg_rd_i && reg_addr_i == `REG_RX_DATA;

    wire [15:0] status = {11'h000, pend_q, addr_match_q, tx_busy_q, rx_error_q, rx_valid_q};

    wire [15:0] rd_mux =
        reg_addr_i == `REG_CMD_SRC    ? {8'h00, command_source_select_q} :
        reg_addr_i == `REG_LINK_SPEED ? {8'h00, link_speed_select_q}     :
        reg_addr_i == `REG_NODE_ADDR  ? {8'h00, node_address_setting_q}  :
        reg_addr_i == `REG_CHAR_LEN   ? {8'h00, char_length_select_q}    :
        reg_addr_i == `REG_PARITY     ? {8'h00, parity_select_q}         :
        reg_addr_i == `REG_STOP_BITS  ? {8'h00, stop_bits_select_q}      :
        reg_addr_i == `REG_REPLY_WAIT ? reply_wait_time_q                :
        reg_addr_i == `REG_STATUS     ? status                           :
        reg_addr_i == `REG_RX_DATA    ? {8'h00, rx_data_q}               :
                                        16'h0000;

    // an error-free first character equal to the node address opens a message; a newline ends it
    wire addr_hit  = rx_char.valid && !rx_char.error && first_char_q
                     && rx_char.data == node_address_setting_q;
    wire msg_end   = rx_char.valid && rx_char.data == 8'h0A;
    wire tick_done = (tick_q == TICK_MS - 1);
    wire start_tx  = pend_q && ms_cnt_q == 16'h0000 && !tx_busy_q;

    // frame: start, data lsb first, optional parity, stop bits
    wire        tx_par   = ^tx_hold_q[6:0] ^ (cfg.eight_bits & tx_hold_q[7])
                           ^ (cfg.parity == 2'h2);
    wire [3:0]  tx_len   = 4'h9 + {3'h0, cfg.eight_bits} + {3'h0, cfg.parity != 2'h0}
                           + {3'h0, cfg.two_stops};
    wire [11:0] tx_frame = cfg.eight_bits
        ? (cfg.parity != 2'h0 ? {2'b11, tx_par, tx_hold_q, 1'b0}
                              : {3'b111, tx_hold_q, 1'b0})
        : (cfg.parity != 2'h0 ? {3'b111, tx_par, tx_hold_q[6:0], 1'b0}
                              : {4'b1111, tx_hold_q[6:0], 1'b0});

    serial_rx u_rx
    (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .cfg_i  (cfg),
        .rx_i   (rx_sync_q),
        .char_o (rx_char)
    );

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            command_source_select_q <= `CMD_SRC_RESET;
            link_speed_select_q     <= `LINK_SPEED_RESET;
            node_address_setting_q  <= `NODE_ADDR_RESET;
            char_length_select_q    <= `CHAR_LEN_RESET;
            parity_select_q         <= `PARITY_RESET;
            stop_bits_select_q      <= `STOP_BITS_RESET;
            reply_wait_time_q       <= `REPLY_WAIT_RESET;
            rdata_q                 <= 16'h0000;
            cmd_source_o            <= `CMD_SRC_RESET;
            serial_cmd_en_o         <= 1'b0;
        end
        else
        begin
            if (wr_src)   command_source_select_q <= reg_wdata_i[7:0];
            if (wr_speed) link_speed_select_q     <= reg_wdata_i[7:0];
            if (wr_node)  node_address_setting_q  <= reg_wdata_i[7:0];
            if (wr_len)   char_length_select_q    <= reg_wdata_i[7:0];
            if (wr_par)   parity_select_q         <= reg_wdata_i[7:0];
            if (wr_stop)  stop_bits_select_q      <= reg_wdata_i[7:0];
            if (wr_wait)  reply_wait_time_q       <= reg_wdata_i;
            rdata_q         <= reg_rd_i ? rd_mux : 16'h0000;
            cmd_source_o    <= command_source_select_q;
            serial_cmd_en_o <= (command_source_select_q == SRC_SERIAL);
        end
    end

    assign reg_rdata_o = rdata_q;

    // two flops before the line is used
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= line_rx_i;
            rx_sync_q <= rx_meta_q;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            addr_match_q <= 1'b0;
            first_char_q <= 1'b1;
            rx_valid_q   <= 1'b0;
            rx_error_q   <= 1'b0;
            rx_data_q    <= 8'h00;
            pend_q       <= 1'b0;
            ms_cnt_q     <= 16'h0000;
            tick_q       <= 32'h0000_0000;
        end
        else
        begin
            if (rx_char.valid)
            begin
                first_char_q <= msg_end;
                rx_data_q    <= rx_char.data;
            end
            // new character wins over a read that clears the flag
            rx_valid_q <= rx_char.valid || (rx_valid_q && !rd_rx);
            rx_error_q <= (rx_char.valid && rx_char.error) || (rx_error_q && !rd_rx);
            if (addr_hit)
                addr_match_q <= 1'b1;
            if (msg_end && (addr_match_q || addr_hit))
            begin
                // reply timer starts only once the whole message is in
                addr_match_q <= 1'b0;
                pend_q       <= 1'b1;
                ms_cnt_q     <= reply_wait_time_q;
                tick_q       <= 32'h0000_0000;
            end
            else if (pend_q && ms_cnt_q != 16'h0000)
            begin
                tick_q <= tick_done ? 32'h0000_0000 : tick_q + 32'h0000_0001;
                if (tick_done)
                    ms_cnt_q <= ms_cnt_q - 16'h0001;
            end
            else if (start_tx)
                pend_q <= 1'b0;
        end
    end

    // transmitter: drives the line only while a reply frame is on it
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tx_hold_q  <= 8'h00;
            tx_q       <= 1'b1;
            oe_q       <= 1'b0;
            tx_cnt_q   <= 16'h0000;
            tx_bit_q   <= 4'h0;
            tx_shift_q <= 12'hFFF;
            tx_busy_q  <= 1'b0;
        end
        else
        begin
            if (wr_tx && !tx_busy_q)
                tx_hold_q <= reg_wdata_i[7:0];
            if (start_tx)
            begin
                tx_busy_q  <= 1'b1;
                oe_q       <= 1'b1;
                tx_shift_q <= tx_frame;
                tx_q       <= 1'b0;
                tx_bit_q   <= 4'h0;
                // zero is a counted cycle too; a full reload would stretch each bit
                tx_cnt_q   <= cfg.bit_div - 16'h0001;
            end
            else if (tx_busy_q)
            begin
                if (tx_cnt_q != 16'h0000)
                    tx_cnt_q <= tx_cnt_q - 16'h0001;
                else if (tx_bit_q + 4'h1 == tx_len)
                begin
                    tx_busy_q <= 1'b0;
                    oe_q      <= 1'b0;
                    tx_q      <= 1'b1;
                end
                else
                begin
                    tx_cnt_q   <= cfg.bit_div - 16'h0001;
                    tx_bit_q   <= tx_bit_q + 4'h1;
                    tx_shift_q <= {1'b1, tx_shift_q[11:1]};
                    tx_q       <= tx_shift_q[1];
                end
            end
        end
    end

    assign line_tx_o    = tx_q;
    assign line_tx_oe_o = oe_q;

endmodule

// ### verif/serial_port_checker.sv
`timescale 1ns/100ps
module serial_port_checker
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_rdata_o,
    // line and drive side
    input  wire logic        line_tx_o,
    input  wire logic        line_tx_oe_o,
    input  wire logic [7:0]  cmd_source_o,
    input  wire logic        serial_cmd_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    wire [15:0] rd_at = reg_rd_i ? (16'h0001 << reg_addr_i) : 16'h0000;

    src_read_a: assert property (rd_at[0] |=> reg_rdata_o inside {[16'h0002:16'h0005]})
        else $error("command source read out of range");
    speed_read_a: assert property (rd_at[1] |=> reg_rdata_o inside {[16'h0002:16'h0006]})
        else $error("speed code read out of range");
    node_range_a: assert property (rd_at[2] |=> reg_rdata_o inside {[16'h0001:16'h0020]})
        else $error("node address read out of range");
    len_code_a: assert property (rd_at[3] |=> reg_rdata_o inside {16'h0007, 16'h0008})
        else $error("length code read illegal");
    parity_code_a: assert property (rd_at[4] |=> reg_rdata_o <= 16'h0002)
        else $error("parity code read illegal");
    stop_code_a: assert property (rd_at[5] |=> reg_rdata_o inside {16'h0001, 16'h0002})
        else $error("stop code read illegal");
    wait_range_a: assert property (rd_at[6] |=> reg_rdata_o <= 16'h03E8)
        else $error("wait time read above limit");
    src_output_a: assert property (serial_cmd_en_o |-> cmd_source_o == 8'h03)
        else $error("serial command enable without serial source");
    tx_release_a: assert property (!line_tx_oe_o |-> line_tx_o)
        else $error("line level low while driver off");
    start_frame_a: assert property ($rose(line_tx_oe_o) |-> (line_tx_oe_o && !line_tx_o)[*8])
        else $error("reply does not open with a start bit");

    cover property ($rose(line_tx_oe_o));
    cover property (rd_at[2]);
    cover property (serial_cmd_en_o);
endmodule

bind serial_slave_port serial_port_checker chk (
    .clk_i          (clk_i),
    .nrst_i         (nrst_i),
    .reg_addr_i     (reg_addr_i),
    .reg_rd_i       (reg_rd_i),
    .reg_rdata_o    (reg_rdata_o),
    .line_tx_o      (line_tx_o),
    .line_tx_oe_o   (line_tx_oe_o),
    .cmd_source_o   (cmd_source_o),
    .serial_cmd_en_o(serial_cmd_en_o)
);

// ### verif/host_model.sv
`timescale 1ns/100ps
module host_model
(
    // clock
    input  wire logic clk_i,
    // slave side of the line
    input  wire logic line_tx_i,
    input  wire logic line_tx_oe_i,
    // master drive
    output logic      line_rx_o
);
    int cyc = 0;
    int end_cyc = 0;
    int rise_cyc = 0;
    // a single slave hangs on this segment, well inside the node limit
    // fail-safe bias keeps an undriven line high
    initial line_rx_o = 1'b1;
    always @(posedge clk_i) cyc <= cyc + 1;

    task automatic drive_bit(input logic b, input int div);
        line_rx_o <= b;
        repeat (div) @(posedge clk_i);
    endtask

    // only the master opens an exchange, framed as every node is set
    task automatic send_char(input logic [7:0] d, input int nb, input int par, input int ns,
                             input int div);
        logic [7:0] m;
        m = (nb == 8) ? 8'hFF : 8'h7F;
        drive_bit(1'b0, div);
        for (int i = 0; i < nb; i++) drive_bit(d[i], div);
        if (par != 0) drive_bit((^(d & m)) ^ (par == 2), div);
        repeat (ns) drive_bit(1'b1, div);
        end_cyc = cyc;
    endtask

    // samples at the falling edge, clear of the slave's launch edge
    task automatic recv_char(input int nb, input int par, input int div, output logic [7:0] d,
                             output logic pb, output logic st, output bit seen);
        seen = 0;
        d = 8'h00;
        pb = 1'b0;
        st = 1'b0;
        for (int i = 0; i < 3000 && !seen; i++)
        begin
            @(negedge clk_i);
            seen = line_tx_oe_i;
        end
        if (!seen) return;
        rise_cyc = cyc;
        repeat (div / 2) @(negedge clk_i);
        for (int i = 0; i < nb; i++)
        begin
            repeat (div) @(negedge clk_i);
            d[i] = line_tx_i;
        end
        if (par != 0)
        begin
            repeat (div) @(negedge clk_i);
            pb = line_tx_i;
        end
        repeat (div) @(negedge clk_i);
        st = line_tx_i & line_tx_oe_i;
    endtask
endmodule

// ### verif/serial_slave_port_tb.sv
`timescale 1ns/100ps
`include "serial_port_defs.svh"
module serial_slave_port_tb;
    localparam int TICK = 40;
    localparam int DIV  = 16;
    logic        clk_i;
    logic        nrst_i;
    logic [3:0]  reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [15:0] reg_rdata_o;
    logic        line_rx_i;
    logic        line_tx_o;
    logic        line_tx_oe_o;
    logic [7:0]  cmd_source_o;
    logic        serial_cmd_en_o;
    int          mismatches = 0;
    int          cmp_count = 0;

    serial_slave_port #(.TICK_MS(TICK)) uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .line_rx_i(line_rx_i), .line_tx_o(line_tx_o), .line_tx_oe_o(line_tx_oe_o),
        .cmd_source_o(cmd_source_o), .serial_cmd_en_o(serial_cmd_en_o));
    host_model host (.clk_i(clk_i), .line_tx_i(line_tx_o), .line_tx_oe_i(line_tx_oe_o),
                     .line_rx_o(line_rx_i));

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        check16(reg_rdata_o, exp, "register read");
        @(posedge clk_i);
    endtask

    task automatic test_defaults;
        chk_reg(`REG_CMD_SRC, 16'h0002);
        chk_reg(`REG_LINK_SPEED, 16'h0004);
        chk_reg(`REG_NODE_ADDR, 16'h0001);
        chk_reg(`REG_CHAR_LEN, 16'h0007);
        chk_reg(`REG_PARITY, 16'h0000);
        chk_reg(`REG_STOP_BITS, 16'h0001);
        chk_reg(`REG_REPLY_WAIT, 16'h0000);
        chk_reg(4'hF, 16'h0000);
        check16({8'h00, cmd_source_o}, 16'h0002, "source output");
        $display("test defaults done");
    endtask

    // out-of-range codes must leave the last legal value in place
    task automatic test_ranges;
        logic [3:0]  ra [8] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
        logic [15:0] ok [8] = '{16'h5, 16'h2, 16'h20, 16'h1, 16'h8, 16'h2, 16'h2, 16'h3E8};
        logic [15:0] no [8] = '{16'h6, 16'h7, 16'h21, 16'h0, 16'h6, 16'h3, 16'h0, 16'h3E9};
        for (int i = 0; i < 8; i++)
        begin
            reg_wr(ra[i], ok[i]);
            reg_wr(ra[i], no[i]);
            chk_reg(ra[i], ok[i]);
        end
        for (int c = 5; c >= 2; c--)
        begin
            reg_wr(`REG_CMD_SRC, 16'(c));
            @(negedge clk_i);
            check16({7'h00, serial_cmd_en_o, cmd_source_o}, {7'h00, c == 3, 8'(c)}, "source");
            @(posedge clk_i);
        end
        reg_wr(`REG_CMD_SRC, 16'h0003);
        $display("test ranges done");
    endtask

    // master sends first, 0x33, 0x0A; a reply is judged for content and delay
    task automatic run_msg(input logic [7:0] first, input bit want, input int nb, input int par,
                           input int ns, input int w, input logic [7:0] txd);
        logic [7:0] d;
        logic       pb;
        logic       st;
        logic [7:0] m;
        bit         seen;
        int         lag;
        m = (nb == 8) ? 8'hFF : 8'h7F;
        reg_wr(`REG_LINK_SPEED, 16'h0002);
        reg_wr(`REG_CHAR_LEN, 16'(nb));
        reg_wr(`REG_PARITY, 16'(par));
        reg_wr(`REG_STOP_BITS, 16'(ns));
        reg_wr(`REG_REPLY_WAIT, 16'(w));
        reg_wr(`REG_TX_DATA, {8'h00, txd});
        fork
            begin
                host.send_char(first, nb, par, ns, DIV);
                host.send_char(8'h33, nb, par, ns, DIV);
                host.send_char(8'h0A, nb, par, ns, DIV);
            end
            host.recv_char(nb, par, DIV, d, pb, st, seen);
        join
        check16({15'h0, seen}, {15'h0, want}, "reply present");
        chk_reg(`REG_RX_DATA, 16'h000A);
        if (!seen && want) finish_test();
        if (!seen) return;
        lag = host.rise_cyc - host.end_cyc;
        check16({8'h00, d}, {8'h00, txd & m}, "reply data");
        check16({15'h0, pb}, {15'h0, par != 0 && ((^(txd & m)) ^ (par == 2))}, "parity");
        check16({15'h0, st}, 16'h0001, "stop bit");
        check16({15'h0, lag >= w * TICK - 2 * DIV && lag <= w * TICK + 6}, 16'h0001, "delay");
        // let the reply frame finish before the next test rewrites the framing
        for (int i = 0; i < 400 && line_tx_oe_o; i++) @(negedge clk_i);
        check16({15'h0, line_tx_oe_o}, 16'h0000, "driver released");
        @(posedge clk_i);
    endtask

    task automatic test_other_node;
        reg_wr(`REG_NODE_ADDR, 16'h0005);
        run_msg(8'h07, 1'b0, 8, 0, 1, 0, 8'hC3);
        $display("test other node done");
    endtask

    task automatic test_reply_8e2;
        run_msg(8'h05, 1'b1, 8, 1, 2, 3, 8'hA5);
        $display("test reply 8e2 done");
    endtask

    task automatic test_reply_7o1;
        reg_wr(`REG_NODE_ADDR, 16'h0020);
        run_msg(8'h20, 1'b1, 7, 2, 1, 0, 8'hD6);
        $display("test reply 7o1 done");
    endtask

    initial
    begin
        nrst_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        test_defaults();
        test_ranges();
        test_other_node();
        test_reply_8e2();
        test_reply_7o1();
        finish_test();
    end

    initial
    begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        $display("BAD t=%0t run limit reached", $time);
        finish_test();
    end
endmodule
